// ---- core/au_regs.vh ----
// Constants for the arithmetic unit host handshake
`ifndef AU_REGS_VH
`define AU_REGS_VH
`define AU_ST_BUSY 7
`define AU_ST_SIGN 6
`define AU_ST_ZERO 5
`define AU_ST_ERR_HI 4
`define AU_ST_ERR_LO 1
`define AU_ST_CARRY 0
`define AU_ST_RESET 8'h00
`define AU_ERR_NONE 4'h0
`define AU_ERR_DIV0 4'h8
`define AU_ERR_NEG 4'h4
`define AU_ERR_RANGE 4'hC
`define AU_ERR_UNDER 4'h2
`define AU_ERR_OVER 4'h1
`define AU_CMD_NOP 7'h00
`define AU_CMD_SINGLE_FIXED_ADD 7'h6C
`define AU_CMD_SINGLE_FIXED_SUBTRACT 7'h6D
`define AU_CMD_PUSH 7'h77
`define AU_CMD_POP 7'h78
`define AU_CMD_XCH 7'h79
`define AU_CMD_FLOAT_ADD 7'h10
`define AU_CMD_FLOAT_MULTIPLY 7'h12
`define AU_CMD_FLOAT_DIVIDE 7'h13
`define AU_CYC_SINGLE_FIXED_ADD 9'd17
`define AU_CYC_SINGLE_FIXED_SUBTRACT 9'd30
`define AU_CYC_NOP 9'd4
`define AU_CYC_PUSH 9'd16
`define AU_CYC_POP 9'd10
`define AU_CYC_XCH 9'd18
`define AU_CYC_FLOAT_ADD_MIN 9'd54
`define AU_CYC_FLOAT_ADD_MAX 9'd368
`define AU_CYC_FLOAT_MULTIPLY_MIN 9'd146
`define AU_CYC_FLOAT_MULTIPLY_MAX 9'd168
`define AU_CYC_FLOAT_DIVIDE_MIN 9'd154
`define AU_CYC_FLOAT_DIVIDE_MAX 9'd184
`define AU_CYC_LATCH 9'd2
`endif

// ---- core/au_fifo.v ----
// Parameterised flip-flop FIFO with valid/ready on both sides
module au_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst_b,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] rd_reg;
  reg [AW-1:0] wr_reg;
  reg [AW:0] cnt_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data = mem_reg[rd_reg];
  always @(posedge clk) begin
    if (push)
      mem_reg[wr_reg] <= in_data;
  end
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_reg <= {AW{1'b0}};
      wr_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                  wr_reg + 1'b1;
      if (pop)
        rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                  rd_reg + 1'b1;
      if (push && !pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule // au_fifo

// ---- core/au_host_port.v ----
// Host handshake, operand stack, status and command timing
`include "au_regs.vh"
module au_host_port #(
  parameter DEPTH = 16,
  parameter PW = 4,
  parameter FIFO_DEPTH = 8
) (
  input wire clk,
  input wire rst_b,
  input wire cs_n,
  input wire cmd_data_select,
  input wire rd_n,
  input wire wr_n,
  input wire [7:0] db_in,
  output reg [7:0] db_out,
  output reg db_oe,
  output reg ready,
  output reg end_n,
  input wire done_ack_n,
  output reg service_request,
  input wire service_ack_n
);
  localparam S_IDLE = 5'b00001;
  localparam S_WAIT = 5'b00010;
  localparam S_LATCH = 5'b00100;
  localparam S_HOLD = 5'b01000;
  localparam S_DONE = 5'b10000;
  // Pin synchronisers
  reg [5:0] s1_reg;
  reg [5:0] s2_reg;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= 6'h3F;
      s2_reg <= 6'h3F;
    end else begin
      s1_reg <= {cs_n, cmd_data_select, rd_n, wr_n, done_ack_n,
                 service_ack_n};
      s2_reg <= s1_reg;
    end
  end
  reg [7:0] d1_reg;
  reg [7:0] d2_reg;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      d1_reg <= 8'h00;
      d2_reg <= 8'h00;
    end else begin
      d1_reg <= db_in;
      d2_reg <= d1_reg;
    end
  end
  wire cs_s = ~s2_reg[5];
  wire sel_s = s2_reg[4];
  wire rd_s = ~s2_reg[3];
  wire wr_s = ~s2_reg[2];
  wire done_ack_n_s = ~s2_reg[1];
  wire sack_s = ~s2_reg[0];
  wire acc = cs_s && (rd_s ^ wr_s);

  reg [4:0] st_reg;
  reg [8:0] exec_cnt_reg;
  reg [8:0] lat_cnt_reg;
  reg [7:0] status_reg;
  reg [7:0] stack_reg [0:DEPTH-1];
  reg [PW-1:0] top_reg;
  reg svc_pend_reg;
  reg [6:0] op_reg;
  reg [8:0] lfsr_reg;
  integer i;

  function [8:0] exec_cycles;
    input [6:0] op;
    input [8:0] rnd;
    begin
      case (op)
        `AU_CMD_SINGLE_FIXED_ADD: exec_cycles = `AU_CYC_SINGLE_FIXED_ADD;
        `AU_CMD_SINGLE_FIXED_SUBTRACT: exec_cycles = `AU_CYC_SINGLE_FIXED_SUBTRACT;
        `AU_CMD_PUSH: exec_cycles = `AU_CYC_PUSH;
        `AU_CMD_POP: exec_cycles = `AU_CYC_POP;
        `AU_CMD_XCH: exec_cycles = `AU_CYC_XCH;
        `AU_CMD_FLOAT_ADD: exec_cycles = `AU_CYC_FLOAT_ADD_MIN +
          (rnd % (`AU_CYC_FLOAT_ADD_MAX - `AU_CYC_FLOAT_ADD_MIN + 9'd1));
        `AU_CMD_FLOAT_MULTIPLY: exec_cycles = `AU_CYC_FLOAT_MULTIPLY_MIN +
          (rnd % (`AU_CYC_FLOAT_MULTIPLY_MAX - `AU_CYC_FLOAT_MULTIPLY_MIN + 9'd1));
        `AU_CMD_FLOAT_DIVIDE: exec_cycles = `AU_CYC_FLOAT_DIVIDE_MIN +
          (rnd % (`AU_CYC_FLOAT_DIVIDE_MAX - `AU_CYC_FLOAT_DIVIDE_MIN + 9'd1));
        default: exec_cycles = `AU_CYC_NOP;
      endcase
    end
  endfunction

  function [PW-1:0] idx;
    input [PW-1:0] base;
    input [PW-1:0] off;
    begin
      idx = base - off;
    end
  endfunction

  // Data write bytes drain into the stack through the FIFO
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire busy = status_reg[`AU_ST_BUSY];
  wire exec_now = busy && (exec_cnt_reg != 9'd0);
  wire drain = fifo_out_valid && !busy;
  reg fifo_push;
  au_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(d2_reg),
    .out_valid(fifo_out_valid),
    .out_ready(drain),
    .out_data(fifo_out_data)
  );

  wire [15:0] top16 = {stack_reg[top_reg], stack_reg[idx(top_reg, 4'd1)]};
  wire [15:0] nos16 = {stack_reg[idx(top_reg, 4'd2)],
                       stack_reg[idx(top_reg, 4'd3)]};
  wire [16:0] sum17 = {1'b0, nos16} + {1'b0, top16};
  wire [16:0] dif17 = {1'b0, nos16} - {1'b0, top16};
  wire [PW-1:0] top_m2 = idx(top_reg, 4'd2);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= S_IDLE;
      exec_cnt_reg <= 9'd0;
      lat_cnt_reg <= 9'd0;
      status_reg <= `AU_ST_RESET;
      top_reg <= {PW{1'b0}};
      svc_pend_reg <= 1'b0;
      op_reg <= `AU_CMD_NOP;
      lfsr_reg <= 9'h1FF;
      db_out <= 8'h00;
      db_oe <= 1'b0;
      ready <= 1'b1;
      end_n <= 1'b1;
      service_request <= 1'b0;
      fifo_push <= 1'b0;
      for (i = 0; i < DEPTH; i = i + 1)
        stack_reg[i] <= 8'h00;
    end else begin
      fifo_push <= 1'b0;
      lfsr_reg <= {lfsr_reg[7:0], lfsr_reg[8] ^ lfsr_reg[4]};
      if (drain) begin
        top_reg <= top_reg + 1'b1;
        stack_reg[top_reg + 1'b1] <= fifo_out_data;
      end
      // Command execution
      if (exec_now) begin
        exec_cnt_reg <= exec_cnt_reg - 9'd1;
        if (exec_cnt_reg == 9'd1) begin
          status_reg[`AU_ST_BUSY] <= 1'b0;
          end_n <= 1'b0;
          if (svc_pend_reg)
            service_request <= 1'b1;
          status_reg[`AU_ST_ERR_HI:`AU_ST_ERR_LO] <= `AU_ERR_NONE;
          status_reg[`AU_ST_CARRY] <= 1'b0;
          status_reg[`AU_ST_SIGN] <= top16[15];
          status_reg[`AU_ST_ZERO] <= (top16 == 16'h0000);
          case (op_reg)
            `AU_CMD_SINGLE_FIXED_ADD: begin
              stack_reg[top_m2] <= sum17[15:8];
              stack_reg[idx(top_reg, 4'd3)] <= sum17[7:0];
              top_reg <= top_m2;
              status_reg[`AU_ST_CARRY] <= sum17[16];
              status_reg[`AU_ST_SIGN] <= sum17[15];
              status_reg[`AU_ST_ZERO] <= (sum17[15:0] == 16'h0000);
              if (nos16[15] == top16[15] && sum17[15] != top16[15])
                status_reg[`AU_ST_ERR_HI:`AU_ST_ERR_LO] <=
                  `AU_ERR_OVER;
            end
            `AU_CMD_SINGLE_FIXED_SUBTRACT: begin
              stack_reg[top_m2] <= dif17[15:8];
              stack_reg[idx(top_reg, 4'd3)] <= dif17[7:0];
              top_reg <= top_m2;
              status_reg[`AU_ST_CARRY] <= dif17[16];
              status_reg[`AU_ST_SIGN] <= dif17[15];
              status_reg[`AU_ST_ZERO] <= (dif17[15:0] == 16'h0000);
              if (nos16[15] != top16[15] && dif17[15] != nos16[15])
                status_reg[`AU_ST_ERR_HI:`AU_ST_ERR_LO] <=
                  `AU_ERR_OVER;
            end
            `AU_CMD_POP: begin
              // Popped word rotates to the bottom
              top_reg <= top_m2;
              status_reg[`AU_ST_SIGN] <= nos16[15];
              status_reg[`AU_ST_ZERO] <= (nos16 == 16'h0000);
            end
            `AU_CMD_PUSH: begin
              stack_reg[top_reg + 4'd2] <= top16[15:8];
              stack_reg[top_reg + 4'd1] <= top16[7:0];
              top_reg <= top_reg + 4'd2;
            end
            `AU_CMD_XCH: begin
              stack_reg[top_reg] <= nos16[15:8];
              stack_reg[idx(top_reg, 4'd1)] <= nos16[7:0];
              stack_reg[top_m2] <= top16[15:8];
              stack_reg[idx(top_reg, 4'd3)] <= top16[7:0];
              status_reg[`AU_ST_SIGN] <= nos16[15];
              status_reg[`AU_ST_ZERO] <= (nos16 == 16'h0000);
            end
            default: begin
            end
          endcase
        end
      end
      // Acknowledges clear the completion outputs
      if (done_ack_n_s)
        end_n <= 1'b1;
      if (sack_s)
        service_request <= 1'b0;
      // Host handshake
      case (st_reg)
        S_IDLE: begin
          if (acc) begin
            ready <= 1'b0;
            if (sel_s && rd_s) begin
              lat_cnt_reg <= `AU_CYC_LATCH;
              st_reg <= S_LATCH;
            end else if (busy) begin
              st_reg <= S_WAIT;
            end else begin
              st_reg <= S_LATCH;
              lat_cnt_reg <= `AU_CYC_LATCH;
            end
          end
        end
        S_WAIT: begin
          if (!busy) begin
            st_reg <= S_LATCH;
            lat_cnt_reg <= `AU_CYC_LATCH;
          end
        end
        S_LATCH: begin
          if (lat_cnt_reg > 9'd1) begin
            lat_cnt_reg <= lat_cnt_reg - 9'd1;
          end else if (sel_s && rd_s) begin
            db_out <= status_reg;
            db_oe <= 1'b1;
            ready <= 1'b1;
            st_reg <= S_HOLD;
          end else if (rd_s && !busy && !fifo_out_valid) begin
            db_out <= stack_reg[top_reg];
            top_reg <= top_reg - 1'b1;
            db_oe <= 1'b1;
            ready <= 1'b1;
            st_reg <= S_HOLD;
          end else if (wr_s && sel_s && !busy && !fifo_out_valid) begin
            op_reg <= d2_reg[6:0];
            svc_pend_reg <= d2_reg[7];
            exec_cnt_reg <= exec_cycles(d2_reg[6:0], lfsr_reg);
            status_reg[`AU_ST_BUSY] <= 1'b1;
            end_n <= 1'b1;
            ready <= 1'b1;
            st_reg <= S_HOLD;
          end else if (wr_s && !sel_s && fifo_in_ready) begin
            fifo_push <= 1'b1;
            ready <= 1'b1;
            st_reg <= S_HOLD;
          end else if (busy) begin
            st_reg <= S_WAIT;
          end
        end
        S_HOLD: begin
          // Bus stays driven until the strobe is released
          if (!(cs_s && (rd_s || wr_s))) begin
            db_oe <= 1'b0;
            st_reg <= S_DONE;
          end
        end
        S_DONE: begin
          st_reg <= S_IDLE;
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end
endmodule // au_host_port

// ---- tb/au_host_port_asserts.sv ----
// Concurrent checks on the host port pins
module au_host_port_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cs_n,
  input wire logic cmd_data_select,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] db_in,
  input wire logic [7:0] db_out,
  input wire logic db_oe,
  input wire logic ready,
  input wire logic end_n,
  input wire logic done_ack_n,
  input wire logic service_request,
  input wire logic service_ack_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence st_req;
    $fell(rd_n) && !cs_n && cmd_data_select;
  endsequence
  sequence dr_req;
    $fell(rd_n) && !cs_n && !cmd_data_select;
  endsequence
  sequence stall;
    ##[1:4] !ready;
  endsequence
  status_fast_a: assert property (
    st_req |-> stall ##[1:4] (ready && db_oe))
    else $error("status read not served promptly");
  data_read_a: assert property (
    dr_req |-> stall ##[1:420] (ready && db_oe))
    else $error("data read not served");
  ready_drops_a: assert property (
    $fell(cs_n) |-> ##[1:4] !ready)
    else $error("ready did not fall on access");
  ready_returns_a: assert property (
    $fell(ready) |-> ##[1:420] ready)
    else $error("ready stuck low");
  quiet_ready_a: assert property (
    cs_n [*4] |-> ready)
    else $error("ready low with no access");
  bus_float_a: assert property (
    rd_n [*6] |-> !db_oe)
    else $error("bus driven without read");
  end_ack_a: assert property (
    $fell(done_ack_n) |-> ##[1:4] end_n)
    else $error("end not cleared by ack");
  svc_ack_a: assert property (
    $fell(service_ack_n) |-> ##[1:4] !service_request)
    else $error("service request not cleared");
  svc_end_a: assert property (
    $rose(service_request) |-> !end_n)
    else $error("service request without end");
endmodule // au_host_port_asserts

// ---- tb/au_host_model.sv ----
// Behavioural host processor for the port
module au_host_model (
  input wire logic clk,
  input wire logic ready,
  input wire logic end_n,
  input wire logic [7:0] db_out,
  output logic cs_n,
  output logic cmd_data_select,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] db_in,
  output logic done_ack_n,
  output logic service_ack_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int cyc = 0;
  int t_rdy = 0;
  int t_end = 0;
  logic e_last = 1'b1;
  logic [7:0] misses = 8'h00;
  initial begin
    cs_n = 1'b1;
    cmd_data_select = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    db_in = 8'h00;
    done_ack_n = 1'b1;
    service_ack_n = 1'b1;
  end
  // Completion edge time, caught even while a task is idling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!end_n && e_last)
      t_end <= cyc;
    e_last <= end_n;
  end
  task automatic acc(input logic sel, input logic rd, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cs_n <= 1'b0;
    cmd_data_select <= sel;
    rd_n <= !rd;
    wr_n <= rd;
    db_in <= d;
    while (ready && n < 8) begin
      @(posedge clk);
      n++;
    end
    if (n == 8)
      misses = misses + 8'h01;
    // Strobes stay put until ready seen high
    while (!ready && n < 600) begin
      @(posedge clk);
      n++;
    end
    if (n >= 600)
      misses = misses + 8'h01;
    t_rdy = cyc;
    q = db_out;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    db_in <= ~d;
    // Idle gap long enough for the synchronisers to see the release
    repeat (5) @(posedge clk);
  endtask
  task automatic ack(input logic svc);
    @(posedge clk);
    if (svc)
      service_ack_n <= 1'b0;
    else
      done_ack_n <= 1'b0;
    repeat (2) @(posedge clk);
    service_ack_n <= 1'b1;
    done_ack_n <= 1'b1;
  endtask
  task automatic wait_end();
    int n;
    n = 0;
    while (end_n !== 1'b0 && n < 600) begin
      @(posedge clk);
      n++;
    end
    if (n >= 600)
      misses = misses + 8'h01;
    // Let the completion time stamp settle before anyone reads it
    #1;
  endtask
endmodule // au_host_model

// ---- tb/test_arith_unit_host_handshake.sv ----
// Self-checking bench for the host handshake port
`include "au_regs.vh"
module test_arith_unit_host_handshake;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, cs_n, cmd_data_select, rd_n, wr_n, db_oe, ready;
  logic end_n, done_ack_n, service_request, service_ack_n;
  logic [7:0] db_in, db_out, q;
  int err_total = 0;
  int cmp_count = 0;
  int tmo = 0;
  logic [15:0] av[4] = '{16'hFFFF, 16'h8000, 16'h0001, 16'h0001};
  logic [15:0] bv[4] = '{16'hFFFF, 16'h8000, 16'h0001, 16'h0002};
  logic [15:0] rv[4] = '{16'hFFFE, 16'h0000, 16'h0002, 16'hFFFF};
  logic [7:0] sv[4] = '{8'h41, 8'h23, 8'h00, 8'h41};
  logic [6:0] op[4] = '{`AU_CMD_SINGLE_FIXED_ADD, `AU_CMD_SINGLE_FIXED_ADD, `AU_CMD_SINGLE_FIXED_ADD,
    `AU_CMD_SINGLE_FIXED_SUBTRACT};
  logic [6:0] tc[9] = '{`AU_CMD_NOP, `AU_CMD_SINGLE_FIXED_ADD, `AU_CMD_SINGLE_FIXED_SUBTRACT,
    `AU_CMD_PUSH, `AU_CMD_POP, `AU_CMD_XCH, `AU_CMD_FLOAT_ADD, `AU_CMD_FLOAT_MULTIPLY,
    `AU_CMD_FLOAT_DIVIDE};
  int lo[9] = '{`AU_CYC_NOP, `AU_CYC_SINGLE_FIXED_ADD, `AU_CYC_SINGLE_FIXED_SUBTRACT, `AU_CYC_PUSH,
    `AU_CYC_POP, `AU_CYC_XCH, `AU_CYC_FLOAT_ADD_MIN, `AU_CYC_FLOAT_MULTIPLY_MIN,
    `AU_CYC_FLOAT_DIVIDE_MIN};
  int hi[9] = '{`AU_CYC_NOP, `AU_CYC_SINGLE_FIXED_ADD, `AU_CYC_SINGLE_FIXED_SUBTRACT, `AU_CYC_PUSH,
    `AU_CYC_POP, `AU_CYC_XCH, `AU_CYC_FLOAT_ADD_MAX, `AU_CYC_FLOAT_MULTIPLY_MAX,
    `AU_CYC_FLOAT_DIVIDE_MAX};
  au_host_port u_dut (.clk(clk), .rst_b(rst_b), .cs_n(cs_n),
    .cmd_data_select(cmd_data_select), .rd_n(rd_n), .wr_n(wr_n),
    .db_in(db_in), .db_out(db_out), .db_oe(db_oe), .ready(ready),
    .end_n(end_n), .done_ack_n(done_ack_n),
    .service_request(service_request), .service_ack_n(service_ack_n));
  au_host_model u_host (.clk(clk), .ready(ready), .end_n(end_n),
    .db_out(db_out), .cs_n(cs_n), .cmd_data_select(cmd_data_select),
    .rd_n(rd_n), .wr_n(wr_n), .db_in(db_in), .done_ack_n(done_ack_n),
    .service_ack_n(service_ack_n));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic end_sim();
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Longest path is under two thousand cycles
  always @(posedge clk) begin
    tmo <= tmo + 1;
    if (tmo == 20000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int l, input int h);
    cmp_count++;
    if (got < l || got > h) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, l);
    end
  endtask
  task automatic push_word(input logic [15:0] w);
    u_host.acc(1'b0, 1'b0, w[7:0], q);
    u_host.acc(1'b0, 1'b0, w[15:8], q);
  endtask
  task automatic cmd(input logic [7:0] c);
    u_host.acc(1'b1, 1'b0, c, q);
  endtask
  initial begin
    rst_b = 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    u_host.acc(1'b1, 1'b1, 8'h00, q);
    chk8(q, `AU_ST_RESET);
    for (int i = 0; i < 4; i++) begin
      push_word(av[i]);
      push_word(bv[i]);
      cmd({1'b0, op[i]});
      u_host.wait_end();
      u_host.ack(1'b0);
      u_host.acc(1'b1, 1'b1, 8'h00, q);
      chk8(q, sv[i]);
      u_host.acc(1'b0, 1'b1, 8'h00, q);
      chk8(q, rv[i][15:8]);
      u_host.acc(1'b0, 1'b1, 8'h00, q);
      chk8(q, rv[i][7:0]);
    end
    for (int i = 0; i < 9; i++) begin
      cmd({1'b0, tc[i]});
      u_host.wait_end();
      chk_rng(u_host.t_end - u_host.t_rdy, lo[i], hi[i]);
      u_host.ack(1'b0);
    end
    cmd({1'b1, `AU_CMD_SINGLE_FIXED_SUBTRACT});
    u_host.acc(1'b1, 1'b1, 8'h00, q);
    chk8(q & 8'h80, 8'h80);
    chk8({7'h00, end_n}, 8'h01);
    u_host.acc(1'b0, 1'b1, 8'h00, q);
    chk_rng(u_host.t_rdy - u_host.t_end, 0, 8);
    chk8({7'h00, service_request}, 8'h01);
    u_host.ack(1'b1);
    u_host.ack(1'b0);
    cmd({1'b0, `AU_CMD_SINGLE_FIXED_SUBTRACT});
    cmd({1'b0, `AU_CMD_SINGLE_FIXED_SUBTRACT});
    chk_rng(u_host.t_rdy - u_host.t_end, 0, 8);
    u_host.ack(1'b0);
    u_host.wait_end();
    chk_rng(u_host.t_end - u_host.t_rdy, lo[2], hi[2]);
    u_host.ack(1'b0);
    chk8(u_host.misses, 8'h00);
    end_sim();
  end
endmodule // test_arith_unit_host_handshake
bind au_host_port au_host_port_asserts u_chk (.clk(clk), .rst_b(rst_b),
  .cs_n(cs_n), .cmd_data_select(cmd_data_select), .rd_n(rd_n),
  .wr_n(wr_n), .db_in(db_in), .db_out(db_out), .db_oe(db_oe),
  .ready(ready), .end_n(end_n), .done_ack_n(done_ack_n),
  .service_request(service_request), .service_ack_n(service_ack_n));
